// >>> nsr_reporter.sv
/*
 * nsr_reporter: turns decoded, checked subframes into report messages of
 * a header beat followed by 32-bit payload words. Assumes the decoder
 * gives raw bits, parity verdict and polarity under a valid/ready handshake,
 * holding in_valid while in_ready is low. Registers on classic Wishbone.
 */
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module nsr_reporter #(
    parameter int WORD_W = 32
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire nsr_pkg::nsr_sub_t in_sub,
    output logic in_ready,
    output logic out_valid,
    output logic out_hdr,
    output logic [WORD_W-1:0] out_data,
    output logic out_last,
    input wire logic out_ready,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {NSR_IDLE, NSR_HDR, NSR_DATA} nsr_state_t;
    nsr_state_t state_reg, state_next;
    nsr_pkg::nsr_hdr_t hdr_reg, hdr_next;
    logic [nsr_pkg::MAX_WORDS*32-1:0] buf_reg, buf_next;
    logic [3:0] idx_reg, idx_next;
    logic enable_reg, enable_next;
    logic [nsr_pkg::CNT_W-1:0] sent_reg, sent_next;
    logic [nsr_pkg::CNT_W-1:0] drop_reg, drop_next;
    logic in_ready_reg, in_ready_next;
    logic out_valid_reg, out_valid_next;
    logic out_hdr_reg, out_hdr_next;
    logic [WORD_W-1:0] out_data_reg, out_data_next;
    logic out_last_reg, out_last_next;
    logic [31:0] wb_dat_reg, wb_dat_next;
    logic wb_ack_reg, wb_ack_next;
    logic take;

    // words per constellation; unknown systems get the ten-word form
    function automatic logic [3:0] words_for(input logic [7:0] id);
        if (id == nsr_pkg::GNSS_GLO)
            return nsr_pkg::WORDS_GLO;
        else if (id == nsr_pkg::GNSS_GAL || id == nsr_pkg::GNSS_SBAS)
            return nsr_pkg::WORDS_EIGHT;
        else
            return nsr_pkg::WORDS_TEN;
    endfunction

    // format raw subframe into word image
    function automatic logic [nsr_pkg::MAX_WORDS*32-1:0] format_bits(
        input nsr_pkg::nsr_sub_t s);
        logic [nsr_pkg::MAX_WORDS*32-1:0] v;
        // pad bits of 30-bit words are not cleared (only inverted with the rest when invert is set), host masks them
        v = s.bits;
        if (s.invert)
            v = ~v;
        if (s.hdr.gnss_id == nsr_pkg::GNSS_GLO)
        begin
            // string bit 85 is the idle chip, forced low
            v[nsr_pkg::MAX_WORDS*32-1 - (nsr_pkg::GLO_BITS-1)] = 1'b0;
        end
        return v;
    endfunction

    assign take = in_valid && in_ready_reg;

    // ------------------------------------------------------------------
    // framer next state
    // ------------------------------------------------------------------
    // a subframe failing parity is swallowed, counted only while enabled, never reported
    always_comb
    begin
        state_next = state_reg;
        hdr_next = hdr_reg;
        buf_next = buf_reg;
        idx_next = idx_reg;
        sent_next = sent_reg;
        drop_next = drop_reg;
        in_ready_next = in_ready_reg;
        out_valid_next = out_valid_reg;
        out_hdr_next = out_hdr_reg;
        out_data_next = out_data_reg;
        out_last_next = out_last_reg;
        case (state_reg)
            NSR_IDLE:
            begin
                in_ready_next = 1'b1;
                if (take)
                begin
                    if (enable_reg && in_sub.parity_ok)
                    begin
                        hdr_next = in_sub.hdr;
                        hdr_next.payload_word_count =
                            words_for(in_sub.hdr.gnss_id);
                        buf_next = format_bits(in_sub);
                        in_ready_next = 1'b0;
                        out_valid_next = 1'b1;
                        out_hdr_next = 1'b1;
                        out_last_next = 1'b0;
                        out_data_next = {4'h0, hdr_next.payload_word_count,
                            hdr_next.signal_id, hdr_next.sv_id,
                            hdr_next.gnss_id};
                        idx_next = 4'h0;
                        state_next = NSR_HDR;
                    end
                    else if (enable_reg)
                        drop_next = drop_reg + 1'b1;
                end
            end
            NSR_HDR, NSR_DATA:
            begin
                if (out_ready)
                begin
                    if (out_last_reg)
                    begin
                        out_valid_next = 1'b0;
                        out_last_next = 1'b0;
                        in_ready_next = 1'b1;
                        sent_next = sent_reg + 1'b1;
                        state_next = NSR_IDLE;
                    end
                    else
                    begin
                        // words leave in received order, first word first
                        out_hdr_next = 1'b0;
                        out_data_next = buf_reg[nsr_pkg::MAX_WORDS*32-1 -:32];
                        buf_next = {buf_reg[nsr_pkg::MAX_WORDS*32-33:0],
                            32'h0000_0000};
                        idx_next = idx_reg + 4'h1;
                        out_last_next =
                            (idx_reg + 4'h1 == hdr_reg.payload_word_count);
                        state_next = NSR_DATA;
                    end
                end
            end
            default:
                state_next = NSR_IDLE;
        endcase
    end

    // framer registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= NSR_IDLE;
            hdr_reg <= '0;
            buf_reg <= '0;
            idx_reg <= 4'h0;
            sent_reg <= '0;
            drop_reg <= '0;
            in_ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            out_hdr_reg <= 1'b0;
            out_data_reg <= '0;
            out_last_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            hdr_reg <= hdr_next;
            buf_reg <= buf_next;
            idx_reg <= idx_next;
            sent_reg <= sent_next;
            drop_reg <= drop_next;
            in_ready_reg <= in_ready_next;
            out_valid_reg <= out_valid_next;
            out_hdr_reg <= out_hdr_next;
            out_data_reg <= out_data_next;
            out_last_reg <= out_last_next;
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    // one-cycle answer; ack drops after one cycle so no double access
    always_comb
    begin
        enable_next = enable_reg;
        wb_ack_next = 1'b0;
        wb_dat_next = 32'h0000_0000;
        // write lands on the edge where the master samples ack
        if (wb_cyc_i && wb_stb_i && wb_ack_reg && wb_we_i && wb_sel_i[0]
            && wb_adr_i == nsr_pkg::CTRL_OFF)
            enable_next = wb_dat_i[nsr_pkg::CTRL_EN_BIT];
        if (wb_cyc_i && wb_stb_i && !wb_ack_reg)
        begin
            wb_ack_next = 1'b1;
            if (wb_adr_i == nsr_pkg::CTRL_OFF)
                wb_dat_next = {31'h0000_0000, enable_reg};
            else if (wb_adr_i == nsr_pkg::STAT_OFF)
                wb_dat_next = {26'h000_0000, idx_reg, state_reg};
            else if (wb_adr_i == nsr_pkg::COUNT_OFF)
                wb_dat_next = {drop_reg, sent_reg};
            else
                wb_dat_next = nsr_pkg::BUS_ERR_DATA;
        end
    end

    // bus registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            enable_reg <= nsr_pkg::CTRL_RESET[nsr_pkg::CTRL_EN_BIT];
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0000_0000;
        end
        else
        begin
            enable_reg <= enable_next;
            wb_ack_reg <= wb_ack_next;
            wb_dat_reg <= wb_dat_next;
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_hdr = out_hdr_reg;
    assign out_data = out_data_reg;
    assign out_last = out_last_reg;
    assign wb_dat_o = wb_dat_reg;
    assign wb_ack_o = wb_ack_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_no_report_bad;
        @(posedge clock) disable iff (rst)
        (take && !in_sub.parity_ok) |=> !out_valid;
    endproperty
    a_no_report_bad: assert property (p_no_report_bad)
        else $error("failed subframe produced a report");

    property p_report_good;
        @(posedge clock) disable iff (rst)
        (take && enable_reg && in_sub.parity_ok) |=> (out_valid && out_hdr);
    endproperty
    a_report_good: assert property (p_report_good)
        else $error("good subframe gave no header beat");

    property p_disabled_silent;
        @(posedge clock) disable iff (rst)
        (take && !enable_reg) |=> !out_valid;
    endproperty
    a_disabled_silent: assert property (p_disabled_silent)
        else $error("report while reporting disabled");

    property p_glo_count;
        @(posedge clock) disable iff (rst)
        (out_hdr && out_valid && hdr_reg.gnss_id == nsr_pkg::GNSS_GLO) |->
            out_data[27:24] == nsr_pkg::WORDS_GLO;
    endproperty
    a_glo_count: assert property (p_glo_count)
        else $error("glonass word count wrong");

    property p_gps_count;
        @(posedge clock) disable iff (rst)
        (out_hdr && out_valid && hdr_reg.gnss_id == nsr_pkg::GNSS_GPS) |->
            out_data[27:24] == nsr_pkg::WORDS_TEN;
    endproperty
    a_gps_count: assert property (p_gps_count)
        else $error("gps word count wrong");

    property p_eight_count;
        @(posedge clock) disable iff (rst)
        (out_hdr && out_valid && (hdr_reg.gnss_id == nsr_pkg::GNSS_GAL ||
            hdr_reg.gnss_id == nsr_pkg::GNSS_SBAS)) |->
            out_data[27:24] == nsr_pkg::WORDS_EIGHT;
    endproperty
    a_eight_count: assert property (p_eight_count)
        else $error("galileo or sbas word count wrong");

    property p_last_at_count;
        @(posedge clock) disable iff (rst)
        (out_valid && out_last) |-> idx_reg == hdr_reg.payload_word_count;
    endproperty
    a_last_at_count: assert property (p_last_at_count)
        else $error("last word not at word count");

    property p_hold;
        @(posedge clock) disable iff (rst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed while stalled");
endmodule

// >>> nsr_pkg.sv
/*
 * nsr_pkg: constants and carrier types for the navigation subframe
 * reporter. Assumes a single 250 MHz clock domain and a Wishbone master.
 */
// Contract
// - with reporting enabled, each finished subframe yields its own report
// - report only complete subframes that passed every parity check
// - payload holds raw bits, keeping preamble and check bits
// - payload packed in 32-bit words, word count field states how many
// - report carries constellation id; host picks layout from it
// - bits needing inversion for parity are inverted before reporting
// - GPS legacy and BeiDou: ten words in over-the-air order
// - GPS L2C and L5: one CNAV message in ten words
// - GLONASS string of 85 bits spread over first three words
// - GLONASS bits 1-8 Hamming, 81-84 string number, bit 85 zero
// - fourth GLONASS word holds frame numbers, unknown ones zero
// - GLONASS data before satellite identified uses satellite id 255
// - BeiDou words: two top bits are padding, host ignores them
// - Galileo E1-B and E5b: I/NAV page pair in eight words
// - Galileo alert pages reported like nominal pages
// - Galileo E5a: F/NAV page in eight words
// - SBAS: 250-bit block in eight 32-bit words
// - constellation ids GPS 0 SBAS 1 GAL 2 BDS 3 QZSS 5 GLO 6
package nsr_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] COUNT_OFF = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
    // ------------------------------------------------------------------
    // constellation ids
    // ------------------------------------------------------------------
    localparam logic [7:0] GNSS_GPS = 8'h00;
    localparam logic [7:0] GNSS_SBAS = 8'h01;
    localparam logic [7:0] GNSS_GAL = 8'h02;
    localparam logic [7:0] GNSS_BDS = 8'h03;
    localparam logic [7:0] GNSS_QZSS = 8'h05;
    localparam logic [7:0] GNSS_GLO = 8'h06;
    localparam logic [7:0] SV_UNKNOWN = 8'hFF;
    // ------------------------------------------------------------------
    // word counts and bit widths
    // ------------------------------------------------------------------
    localparam logic [3:0] WORDS_TEN = 4'hA;
    localparam logic [3:0] WORDS_EIGHT = 4'h8;
    localparam logic [3:0] WORDS_GLO = 4'h4;
    localparam int MAX_WORDS = 10;
    localparam int GLO_BITS = 85;
    localparam int BDS_DATA_BITS = 30;
    localparam int SBAS_BITS = 250;
    localparam int CNT_W = 16;

    // header of one report
    typedef struct packed {
        logic [7:0] gnss_id;
        logic [7:0] sv_id;
        logic [7:0] signal_id;
        logic [3:0] payload_word_count;
    } nsr_hdr_t;

    // one decoded subframe from the receiver
    typedef struct packed {
        nsr_hdr_t hdr;
        logic parity_ok;
        logic invert;
        logic [MAX_WORDS*32-1:0] bits;
    } nsr_sub_t;
endpackage

// >>> nsr_host_model.sv
/*
 * nsr_host_model: message sink standing in for the host side.
 * assumes the bench picks prompt or stalling behaviour through slow.
 */
`timescale 1ns/100ps
module nsr_host_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    output logic out_ready
);
    // ----------------------------------------------------------------
    // ready handshake
    // ----------------------------------------------------------------
    // ready moves only after an edge; random stalls exercise beat holding
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            out_ready <= 1'b0;
        else
            out_ready <= !slow || ($urandom() % 3 == 0);
    end
endmodule

// >>> nsr_reporter_test.sv
/*
 * nsr_reporter_test: self-checking bench for the subframe reporter.
 * assumes the host model drains the stream and wishbone sets enable.
 */
`timescale 1ns/100ps
module nsr_reporter_test;
    logic clock, rst, in_valid, slow, en;
    logic in_ready, out_valid, out_hdr, out_last, out_ready;
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [31:0] out_data, wb_dat_i, wb_dat_o, rd;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    nsr_pkg::nsr_sub_t in_sub;
    logic [67:0] exp_q[$];
    logic [7:0] ids[6];
    int err_count, compares, sent, dropped;

    nsr_reporter dut_u (.clock(clock), .rst(rst), .in_valid(in_valid),
        .in_sub(in_sub), .in_ready(in_ready), .out_valid(out_valid),
        .out_hdr(out_hdr), .out_data(out_data), .out_last(out_last),
        .out_ready(out_ready), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    nsr_host_model host_u (.clock(clock), .rst(rst), .slow(slow),
        .out_ready(out_ready));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // masked compare; mask clears fields the host must not trust
    task automatic check(input logic [33:0] got, exp, m);
        compares++;
        if ((got & m) !== (exp & m))
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single cycle; waits for ack, no fixed latency assumed
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // only the watchdog ends a wait for ack
        do
        begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check({2'b0, rd}, {2'b0, e}, 34'h3_FFFF_FFFF);
    endtask

    // offers one subframe and notes the beats it must produce
    task automatic send(input logic [7:0] g, sv, input logic ok, inv);
        nsr_pkg::nsr_sub_t s;
        logic [319:0] w;
        logic [3:0] c;
        for (int i = 0; i < 10; i++)
            s.bits[32*i +: 32] = $urandom();
        s.hdr = {g, sv, 8'($urandom() % 9), 4'h0};
        s.parity_ok = ok;
        s.invert = inv;
        c = (g == nsr_pkg::GNSS_GLO) ? nsr_pkg::WORDS_GLO :
            (g == nsr_pkg::GNSS_GAL || g == nsr_pkg::GNSS_SBAS) ?
            nsr_pkg::WORDS_EIGHT : nsr_pkg::WORDS_TEN;
        w = inv ? ~s.bits : s.bits;
        if (g == nsr_pkg::GNSS_GLO)
            w[235] = 1'b0;
        if (en && ok)
        begin
            exp_q.push_back({34'h3_FFFF_FFFF, 2'b10, 4'h0, c,
                             s.hdr.signal_id, sv, g});
            for (int i = 0; i < c; i++)
                exp_q.push_back({(g == nsr_pkg::GNSS_BDS) ? 34'h3_3FFF_FFFF
                    : 34'h3_FFFF_FFFF, 1'b0, 1'(i == c - 1),
                    w[319-32*i -: 32]});
            sent++;
        end
        else if (en)
            dropped++;
        @(posedge clock);
        in_sub <= s;
        in_valid <= 1'b1;
        do
        begin
            @(posedge clock);
        end while (in_ready !== 1'b1);
        in_valid <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // clock, monitor and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // a beat with no note left is checked against its own inverse, so it always mismatches
    always @(posedge clock)
    begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            logic [67:0] e;
            e = exp_q.size() ? exp_q.pop_front() :
                {34'h3_FFFF_FFFF, ~{out_hdr, out_last, out_data}};
            check({out_hdr, out_last, out_data}, e[33:0], e[67:34]);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        final_report();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int n;
        rst = 1'b1;
        in_valid = 1'b0;
        in_sub = '0;
        slow = 1'b0;
        en = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hF;
        ids = '{nsr_pkg::GNSS_GPS, nsr_pkg::GNSS_SBAS, nsr_pkg::GNSS_GAL,
                nsr_pkg::GNSS_BDS, nsr_pkg::GNSS_QZSS, nsr_pkg::GNSS_GLO};
        void'($urandom(32'h548C));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rdchk(nsr_pkg::CTRL_OFF, nsr_pkg::CTRL_RESET);
        rdchk(nsr_pkg::COUNT_OFF, 32'h0);
        rdchk(nsr_pkg::STAT_OFF, 32'h0);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rdchk(8'h3C, nsr_pkg::BUS_ERR_DATA);
        send(nsr_pkg::GNSS_GPS, 8'h01, 1'b1, 1'b0);
        wb(1'b1, nsr_pkg::CTRL_OFF, 32'h1);
        en = 1'b1;
        rdchk(nsr_pkg::CTRL_OFF, 32'h1);
        // offers one idle cycle apart, all ids, failures and stalls mixed in
        for (int k = 0; k < 24; k++)
        begin
            slow <= k[1];
            send(ids[k % 6], (k % 6 == 5 && k > 6) ? nsr_pkg::SV_UNKNOWN :
                 8'($urandom() % 32 + 1), k % 7 != 3,
                 k % 6 == 0 && k[2]);
        end
        n = 0;
        while (exp_q.size() != 0 && n < 2000)
        begin
            @(posedge clock);
            n++;
        end
        // every noted beat must have appeared by now
        check(34'(exp_q.size()), 34'h0, 34'h3_FFFF_FFFF);
        rdchk(nsr_pkg::COUNT_OFF, {dropped[15:0], sent[15:0]});
        final_report();
    end
endmodule
